// >>> sim/ncs_pack.sv
`timescale 1ns/10ps
module ncs_pack
  import ncs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic osc_run,
  input wire logic pin_oe,
  input wire logic adc_start,
  input wire logic [ADC_W-1:0] cell_code,
  output logic pin_level,
  output ncs_sample_t adc_result
);
  logic osc = 1'b0;
  int ph = 0;
  int lat = 0;
  // rc time base as a square wave of 300 clocks
  always @(posedge sys_clk) begin
    ph <= (ph == 149) ? 0 : ph + 1;
    if (ph == 149) begin
      osc <= ~osc & osc_run;
    end
  end
  // pin reads low while the device holds it
  assign pin_level = pin_oe ? 1'b0 : osc;
  // conversion ends 6 clocks after start; data churns when not valid
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat <= 0;
      adc_result <= '0;
    end else begin
      lat <= adc_start ? 6 : (lat > 0 ? lat - 1 : 0);
      adc_result.valid <= (lat == 1);
      adc_result.data <= (lat == 1) ? cell_code : ~adc_result.data;
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb;
  import ncs_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  ncs_sense_t sense_in = '0;
  logic [9:0] trickle_pulse_ms = 10'h064;
  logic topoff_select = 1'b1;
  logic osc_run = 1'b1;
  logic [ADC_W-1:0] cell_code = 12'h0800;
  logic pin_level, pin_out, pin_oe, adc_start, sw, lamp_out, lamp_oe;
  ncs_sample_t adc_result;
  ncs_state_t charge_state;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_adc = 0;
  always #5 sys_clk = ~sys_clk;
  ncs_charge_sequencer #(.MS_CYC(10), .MTO_TICKS(128)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .sense_in(sense_in), .timer_program_pin_in(pin_level), .timer_program_pin_out(pin_out),
    .timer_program_pin_oe(pin_oe), .trickle_pulse_ms(trickle_pulse_ms), .topoff_select(topoff_select),
    .adc_start(adc_start), .adc_result(adc_result), .charge_switch_out(sw), .status_lamp_out(lamp_out),
    .status_lamp_oe(lamp_oe), .charge_state(charge_state));
  ncs_pack pack_u (.sys_clk(sys_clk), .rst_n(rst_n), .osc_run(osc_run), .pin_oe(pin_oe),
    .adc_start(adc_start), .cell_code(cell_code), .pin_level(pin_level), .adc_result(adc_result));
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wst(ncs_state_t s, int n);
    int i;
    i = 0;
    while (charge_state !== s && i < n) begin
      cyc(1);
      i++;
    end
    chk(charge_state, s);
  endtask
  task automatic wadc(int k);
    int i;
    i = 0;
    while (n_adc < k && i < 3000) begin
      cyc(1);
      i++;
    end
  endtask
  // every conversion must find the switch off and the pin held low
  always @(negedge sys_clk) begin
    if (adc_start === 1'b1) begin
      n_adc++;
      chk({sw, pin_oe, pin_out}, 3'h2);
      chk(lamp_out, 1'b0);
    end
  end
  task automatic t_cond();
    int hi, on;
    hi = 0;
    on = 0;
    wst(ST_COND, 20);
    repeat (10000) begin
      cyc(1);
      hi += sw;
      on += lamp_oe;
    end
    chk(hi, 1000);
    chk(on, 5000);
    chk(n_adc, 0);
    sense_in.ts_hot = 1'b1;
    sense_in.cell_low = 1'b0;
    cyc(10);
    chk(charge_state, ST_COND);
    sense_in.ts_hot = 1'b0;
    wst(ST_FAST, 10);
  endtask
  task automatic t_expire();
    int t;
    t = 2;
    cyc(2);
    chk(lamp_oe, 1'b1);
    while (charge_state === ST_FAST && t < 40000) begin
      cyc(1);
      t++;
      if (t == 890) chk(n_adc, 0);
    end
    chk(t >= 38000 && t <= 38450, 1'b1);
    chk(charge_state, ST_TOPOFF);
    chk(n_adc > 100, 1'b1);
    cyc(3000);
    chk(charge_state, ST_TOPOFF);
    sense_in.cell_max = 1'b1;
    wst(ST_MAINT, 10);
    sense_in.cell_max = 1'b0;
  endtask
  task automatic t_fast();
    sense_in.bat_present = 1'b0;
    wst(ST_IDLE, 10);
    sense_in.bat_present = 1'b1;
    wst(ST_FAST, 10);
    sense_in.sns_hi = 1'b1;
    cyc(5);
    chk(sw, 1'b0);
    sense_in.sns_hi = 1'b0;
    sense_in.sns_lo = 1'b1;
    cyc(5);
    chk(sw, 1'b1);
    sense_in.sns_lo = 1'b0;
    sense_in.ts_hot = 1'b1;
    cyc(5);
    chk({charge_state, lamp_oe}, {ST_FAST, 1'b1});
    sense_in.ts_hot = 1'b0;
    sense_in.ts_cold = 1'b1;
    wst(ST_COND, 10);
    sense_in.ts_cold = 1'b0;
    wst(ST_FAST, 10);
  endtask
  task automatic t_peak();
    topoff_select = 1'b0;
    n_adc = 0;
    wadc(2);
    cell_code = 12'h07fd;
    n_adc = 0;
    wadc(3);
    chk(charge_state, ST_FAST);
    cell_code = 12'h07fc;
    wst(ST_MAINT, 900);
  endtask
  task automatic t_cut();
    sense_in.sleep_req = 1'b1;
    wst(ST_IDLE, 10);
    sense_in.sleep_req = 1'b0;
    wst(ST_FAST, 10);
    sense_in.ts_hot = 1'b1;
    sense_in.ts_cut = 1'b1;
    wst(ST_SUSP, 10);
    cyc(2);
    chk(lamp_oe, 1'b0);
    sense_in.ts_cut = 1'b0;
    cyc(10);
    chk(charge_state, ST_SUSP);
    sense_in.ts_hot = 1'b0;
    wst(ST_MAINT, 10);
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    sense_in.bat_present = 1'b1;
    sense_in.cell_low = 1'b1;
    cyc(20);
    rst_n = 1'b1;
    chk(charge_state, ST_QUAL);
    t_cond();
    t_expire();
    t_fast();
    t_peak();
    t_cut();
    end_sim();
  end
  initial begin
    #1_000_000;
    n_mismatch++;
    end_sim();
  end
endmodule

// >>> verilog/ncs_charge_sequencer.sv
`timescale 1ns/10ps
// Function
// - restart on power, battery insertion, sleep exit
// - qualify first; low cell enters conditioning
// - conditioning pulses switch once per second
// - lamp blinks 1 Hz during qualification and conditioning
// - conditioning exits only when voltage, temperature good
// - timer frozen during conditioning
// - lamp steadily on in fast charge
// - fast, optional top-off, then maintenance below max
// - peak detect held off for max/32
// - timer expiry leaves fast for top-off/maintenance
// - timer cleared before top-off begins
// - cold in fast pauses timer into conditioning, then resumes
// - hot fault ignored during fast charge
// - hot cutoff in fast/top-off suspends, lamp off, resume maintenance
// - max-cell check in fast, top-off, maintenance; peak drop per max/128
// - switch and timer pin low before sampling
// - adc sampling only in fast charge
// - switch high passes current, low blocks
module ncs_charge_sequencer
  import ncs_pkg::*;
#(
  parameter int MS_CYC = MS_TICK_CYC,
  parameter int MTO_TICKS = MTO_TICKS_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ncs_sense_t sense_in,
  input wire logic timer_program_pin_in,
  output logic timer_program_pin_out,
  output logic timer_program_pin_oe,
  input wire logic [9:0] trickle_pulse_ms,
  input wire logic topoff_select,
  output logic adc_start,
  input wire ncs_sample_t adc_result,
  output logic charge_switch_out,
  output logic status_lamp_out,
  output logic status_lamp_oe,
  output ncs_state_t charge_state
);
  localparam int TW = $clog2(MTO_TICKS + 1);
  localparam int MW = $clog2(MS_CYC);
  localparam logic [TW-1:0] MTO_T = TW'(MTO_TICKS);
  localparam logic [TW-1:0] HOLD_T = TW'(MTO_TICKS / HOLDOFF_DIV);
  localparam logic [TW-1:0] SAMP_LAST = TW'(MTO_TICKS / SAMPLE_DIV - 1);

  if (MTO_TICKS < SAMPLE_DIV || MTO_TICKS % SAMPLE_DIV != 0 || MS_CYC < 2) begin : g_bad
    $error("ncs_charge_sequencer: unusable timing parameters");
  end

  ncs_sense_t s;
  logic rc_s;
  logic rc_prev;
  logic [2:0] rc_hold;
  logic bat_prev;
  logic sleep_prev;
  ncs_state_t state;
  ncs_state_t next_state;
  ncs_samp_t phase;
  ncs_samp_t next_phase;
  logic [7:0] quiet_cnt;
  logic [MW-1:0] ms_cnt;
  logic [9:0] ms_in_sec;
  logic [TW-1:0] timer;
  logic [TW-1:0] samp_cnt;
  logic drop;

  ncs_sync #(.W($bits(ncs_sense_t) + 1)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({timer_program_pin_in, sense_in}),
    .q({rc_s, s})
  );

  // restart and idle decode
  wire cycle_start = (s.bat_present & ~bat_prev) | (sleep_prev & ~s.sleep_req);
  wire go_idle = s.sleep_req | ~s.bat_present;
  wire go_on = !cycle_start && !go_idle;

  // shared time base: oscillator edges and millisecond enables
  // the synchronised pin lags the pin by two edges, so edges are ignored while
  // the pin is held low and for three cycles after its release
  wire rc_rise = rc_s & ~rc_prev & ~timer_program_pin_oe & ~|rc_hold;
  wire ms_tick = (ms_cnt == MW'(MS_CYC - 1));
  wire sec_wrap = ms_tick && (ms_in_sec == PERIOD_LAST);

  wire in_fast = (state == ST_FAST);
  wire expired = (timer >= MTO_T);
  wire holdoff_done = (timer >= HOLD_T);
  wire timer_run = rc_rise & ~expired & (in_fast | (state == ST_TOPOFF));
  wire sample_due = timer_run && in_fast && holdoff_done && (samp_cnt == SAMP_LAST);
  // hot fault is not consulted here during fast charge
  wire temp_ok = !s.ts_cold && !s.ts_hot;
  wire fast_end = in_fast && !s.ts_cut && !s.ts_cold && (expired || drop || s.cell_max);
  wire cond_ok = !s.cell_low && temp_ok;

  // charge-cycle states; idle and restart override every state
  always_comb begin
    next_state = state;
    case (state)
      ST_QUAL: begin
        next_state = cond_ok ? ST_FAST : ST_COND;
      end
      ST_COND: begin
        if (cond_ok) next_state = ST_FAST;
      end
      ST_FAST: begin
        if (s.ts_cut) next_state = ST_SUSP;
        else if (s.ts_cold) next_state = ST_COND;
        else if (fast_end) next_state = topoff_select ? ST_TOPOFF : ST_MAINT;
      end
      ST_TOPOFF: begin
        if (s.ts_cut) next_state = ST_SUSP;
        else if (expired || s.cell_max) next_state = ST_MAINT;
      end
      ST_SUSP: begin
        if (!s.ts_hot) next_state = ST_MAINT;
      end
      default: begin
        next_state = state;
      end
    endcase
    if (go_idle) next_state = ST_IDLE;
    else if (cycle_start) next_state = ST_QUAL;
  end

  // sampling: quiet period with switch and timer pin low, then one conversion
  always_comb begin
    next_phase = phase;
    case (phase)
      SP_IDLE: begin
        if (sample_due) next_phase = SP_QUIET;
      end
      SP_QUIET: begin
        if (quiet_cnt == 8'h00) next_phase = SP_CONV;
      end
      SP_CONV: begin
        if (adc_result.valid) next_phase = SP_IDLE;
      end
      default: begin
        next_phase = SP_IDLE;
      end
    endcase
    if (!in_fast) next_phase = SP_IDLE;
  end

  assign adc_start = (phase == SP_QUIET) && (quiet_cnt == 8'h00) && in_fast;
  wire take = (phase == SP_CONV) && adc_result.valid && in_fast;

  ncs_peak_track u_peak (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(cycle_start | go_idle),
    .take(take),
    .sample(adc_result.data),
    .drop(drop)
  );

  // true during the first part of each second, up to the given millisecond count
  function automatic logic ms_below(input logic [9:0] ms, input logic [9:0] limit);
    return ms < limit;
  endfunction

  // output decode
  wire pulse_on = ms_below(ms_in_sec, trickle_pulse_ms);
  wire top_on = ms_below(ms_in_sec, TOPOFF_PULSE_MS);
  wire blink_on = ms_below(ms_in_sec, BLINK_HALF);
  wire reg_sw = s.sns_hi ? 1'b0 : (s.sns_lo ? 1'b1 : charge_switch_out);
  wire next_sw = (phase != SP_IDLE) ? 1'b0 :
                 in_fast ? reg_sw :
                 (state == ST_COND) ? pulse_on :
                 (state == ST_MAINT) ? (pulse_on & ~s.cell_max) :
                 (state == ST_TOPOFF) ? (top_on & ~s.cell_max) : 1'b0;
  wire next_lamp = in_fast | (((state == ST_QUAL) | (state == ST_COND)) & blink_on);

  assign timer_program_pin_out = 1'b0;
  assign timer_program_pin_oe = (phase != SP_IDLE);
  assign status_lamp_out = 1'b0;
  assign charge_state = state;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_QUAL;
      phase <= SP_IDLE;
      rc_prev <= 1'b0;
      bat_prev <= 1'b0;
      sleep_prev <= 1'b0;
      charge_switch_out <= 1'b0;
      status_lamp_oe <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      rc_prev <= rc_s;
      bat_prev <= s.bat_present;
      sleep_prev <= s.sleep_req;
      charge_switch_out <= next_sw;
      status_lamp_oe <= next_lamp;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) quiet_cnt <= 8'h00;
    else if (phase == SP_IDLE) quiet_cnt <= QUIET_LAST;
    else if (quiet_cnt != 8'h00) quiet_cnt <= quiet_cnt - 8'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rc_hold <= 3'h0;
    else rc_hold <= {rc_hold[1:0], timer_program_pin_oe};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= '0;
      ms_in_sec <= 10'h000;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + MW'(1);
      if (sec_wrap) ms_in_sec <= 10'h000;
      else if (ms_tick) ms_in_sec <= ms_in_sec + 10'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) timer <= '0;
    else if (!go_on) timer <= '0;
    else if (in_fast && next_state == ST_TOPOFF) timer <= '0;
    else if (timer_run) timer <= timer + TW'(1);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) samp_cnt <= '0;
    else if (!go_on) samp_cnt <= '0;
    else if (timer_run && in_fast) samp_cnt <= (samp_cnt == SAMP_LAST) ? '0 : samp_cnt + TW'(1);
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // checks on the charge cycle, each beside the rule it guards
  a_lamp_fast_on: assert property ($past(state) == ST_FAST |-> status_lamp_oe)
    else $error("lamp not on in fast charge");
  a_cond_timer_held: assert property (state == ST_COND && go_on |=> $stable(timer))
    else $error("timer moved in conditioning");
  a_sample_quiet: assert property (phase == SP_CONV |-> !charge_switch_out && timer_program_pin_oe)
    else $error("switch or timer pin not low while sampling");
  a_adc_fast_only: assert property (adc_start |-> state == ST_FAST)
    else $error("adc started outside fast charge");
  a_holdoff_pvd: assert property (adc_start |-> timer >= HOLD_T)
    else $error("sample taken during hold-off");
  a_topoff_clear: assert property ($past(state) == ST_FAST && state == ST_TOPOFF |-> timer == '0)
    else $error("timer not cleared into top-off");
  a_expire_exit: assert property (fast_end && go_on |=> state == (topoff_select ? ST_TOPOFF : ST_MAINT))
    else $error("fast charge did not end on expiry");
  a_cond_to_fast: assert property (state == ST_COND && cond_ok && go_on |=> state == ST_FAST)
    else $error("conditioning did not advance");
  a_cutoff_susp: assert property (in_fast && s.ts_cut && go_on |=> state == ST_SUSP ##1 !status_lamp_oe)
    else $error("hot cutoff not handled");
  a_reg_off: assert property (in_fast && phase == SP_IDLE && s.sns_hi |=> !charge_switch_out)
    else $error("switch not off above high sense");
  a_qual_route: assert property (state == ST_QUAL && s.cell_low && go_on |=> state == ST_COND)
    else $error("low cell did not condition");
  a_quiet_len: assert property ($rose(phase == SP_QUIET) |-> (phase == SP_QUIET || !in_fast)[*8])
    else $error("quiet period too short");

  // state flow after temperature, maximum cell voltage and restart events
  wire fast_stay = in_fast && !s.ts_cut && !s.ts_cold && !fast_end && go_on;
  a_cold_pause: assert property (in_fast && s.ts_cold && !s.ts_cut && go_on |=> state == ST_COND)
    else $error("cold fault did not pause fast charge");
  a_susp_resume: assert property (state == ST_SUSP && !s.ts_hot && go_on |=> state == ST_MAINT)
    else $error("suspend did not resume in maintenance");
  a_hot_ignored: assert property (fast_stay && s.ts_hot |=> in_fast)
    else $error("hot fault left fast charge");
  a_restart_qual: assert property (cycle_start && !go_idle |=> state == ST_QUAL)
    else $error("restart did not enter qualification");
  a_fast_max_end: assert property (in_fast && s.cell_max && !s.ts_cut && !s.ts_cold && go_on |=> !in_fast)
    else $error("fast charge kept above maximum cell voltage");

  // output levels outside fast charge and during sampling
  a_susp_outputs: assert property (state == ST_SUSP |=> !status_lamp_oe && !charge_switch_out)
    else $error("lamp or switch on while suspended");
  a_maint_max_off: assert property (state == ST_MAINT && s.cell_max |=> !charge_switch_out)
    else $error("switch on above maximum cell voltage");
  a_idle_switch_off: assert property (state == ST_IDLE |=> !charge_switch_out)
    else $error("switch on while idle");
  a_quiet_switch_low: assert property (phase != SP_IDLE && $past(phase) != SP_IDLE |-> !charge_switch_out)
    else $error("switch not low before sampling");
  a_cond_blink: assert property (state == ST_COND && ms_in_sec == BLINK_HALF |=> !status_lamp_oe)
    else $error("lamp not off in second half of blink");
  a_cond_pulse: assert property (state == ST_COND && phase == SP_IDLE && ms_in_sec == 10'h000
    && trickle_pulse_ms != 10'h000 |=> charge_switch_out)
    else $error("conditioning pulse missing");

  // main scenarios
  c_fast: cover property (state == ST_QUAL ##1 state == ST_FAST);
  c_topoff: cover property (state == ST_FAST ##1 state == ST_TOPOFF);
  c_drop: cover property (in_fast && drop);
  c_cold_pause: cover property (state == ST_FAST ##1 state == ST_COND);
  c_susp_resume: cover property (state == ST_SUSP ##1 state == ST_MAINT);
endmodule

// >>> verilog/ncs_peak_track.sv
`timescale 1ns/10ps
module ncs_peak_track
  import ncs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic take,
  input wire logic [ADC_W-1:0] sample,
  output logic drop
);
  logic [ADC_W-1:0] peak;
  logic have;
  wire higher = !have || (sample > peak);
  wire [ADC_W-1:0] fall = peak - sample;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      peak <= '0;
      have <= 1'b0;
      drop <= 1'b0;
    end else if (clear) begin
      peak <= '0;
      have <= 1'b0;
      drop <= 1'b0;
    end else if (take) begin
      if (higher) begin
        peak <= sample;
        have <= 1'b1;
      end else if (fall >= PVD_DROP_LSB) begin
        drop <= 1'b1;
      end
    end
  end
endmodule

// >>> verilog/ncs_pkg.sv
package ncs_pkg;
  // base clock
  localparam int SYS_CLK_NS = 10;
  // millisecond enable derived from the base clock
  localparam int MS_TICK_NS = 1_000_000;
  localparam int MS_TICK_CYC = MS_TICK_NS / SYS_CLK_NS;
  // pulse period and lamp blink, counted in millisecond ticks
  localparam int PERIOD_MS = 1000;
  localparam int BLINK_HALF_MS = 500;
  localparam logic [9:0] PERIOD_LAST = 10'h3e7;
  localparam logic [9:0] BLINK_HALF = 10'h1f4;
  // fixed top-off pulse, 1/16 of a second rounded down
  localparam logic [9:0] TOPOFF_PULSE_MS = 10'h03e;
  // quiet time ahead of each cell-voltage sample
  localparam int QUIET_NS = 2000;
  localparam int QUIET_CYC = (QUIET_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [7:0] QUIET_LAST = 8'(QUIET_CYC - 1);
  // maximum charge time in timer-oscillator periods
  localparam int MTO_TICKS_DEF = 16384;
  localparam int HOLDOFF_DIV = 32;
  localparam int SAMPLE_DIV = 128;
  // cell-voltage adc, peak drop of 3.8 mV in adc steps
  localparam int ADC_W = 12;
  localparam real PVD_MV = 3.8;
  localparam logic [11:0] PVD_DROP_LSB = 12'h004;

  typedef enum logic [2:0] {
    ST_QUAL = 3'b000,
    ST_COND = 3'b001,
    ST_FAST = 3'b011,
    ST_TOPOFF = 3'b010,
    ST_MAINT = 3'b110,
    ST_SUSP = 3'b111,
    ST_IDLE = 3'b101
  } ncs_state_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_QUIET = 2'b01,
    SP_CONV = 2'b11
  } ncs_samp_t;

  // comparator results, each high when the condition holds
  typedef struct packed {
    logic cell_low;     // cell voltage below low_cell_threshold
    logic cell_max;     // cell voltage above max_cell_threshold
    logic ts_cold;      // thermistor above cold_fault_threshold
    logic ts_hot;       // thermistor below hot_fault_threshold
    logic ts_cut;       // thermistor below hot_cutoff_threshold
    logic sns_hi;       // current sense above high threshold
    logic sns_lo;       // current sense below low threshold
    logic bat_present;  // battery present
    logic sleep_req;    // sleep level on the cell input
  } ncs_sense_t;

  typedef struct packed {
    logic valid;
    logic [ADC_W-1:0] data;
  } ncs_sample_t;
endpackage

// >>> verilog/ncs_sync.sv
`timescale 1ns/10ps
module ncs_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
